// ---- hcd_filter.sv ----
/*
 Hall noise filter: prescaled sampling and per-input confirmation count.
 Assumes raw hall inputs already synchronous to clk_sys.
*/
`timescale 1ns/10ps
`include "hcd_map.svh"
module hcd_filter
	import hcd_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic resetn,
	hcd_flt_if.filt   flt
);
	logic [6:0] pre_reg;
	logic [4:0] cnt_reg [3];
	logic [2:0] filt_reg;
	logic       tick;
	logic [4:0] need;

	function automatic logic [6:0] div_mask(input logic [2:0] sel);
		div_mask = 7'((8'h02 << sel) - 8'h01);
	endfunction

	always_ff @(posedge clk_sys) begin
		if (!resetn)
			pre_reg <= 7'h00;
		else
			pre_reg <= pre_reg + 7'h01;
	end

	// Code 111 gives no sample ticks, so the filtered level holds
	assign tick = (flt.clk_sel != `HCD_FLT_SEL_NONE) &&
		((pre_reg & div_mask(flt.clk_sel)) == div_mask(flt.clk_sel));
	// A count of zero still needs one confirming sample
	assign need = (flt.checks == 5'h00) ? 5'h01 : flt.checks;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			filt_reg <= 3'h0;
			for (int i = 0; i < 3; i++)
				cnt_reg[i] <= 5'h00;
		end else if (!flt.enable) begin
			filt_reg <= flt.raw;
			for (int i = 0; i < 3; i++)
				cnt_reg[i] <= 5'h00;
		end else if (tick) begin
			for (int i = 0; i < 3; i++) begin
				if (flt.raw[i] == filt_reg[i]) begin
					cnt_reg[i] <= 5'h00;
				end else if (cnt_reg[i] + 5'h01 >= need) begin
					filt_reg[i] <= flt.raw[i];
					cnt_reg[i] <= 5'h00;
				end else begin
					cnt_reg[i] <= cnt_reg[i] + 5'h01;
				end
			end
		end
	end

	assign flt.filtered = filt_reg;

	a_filter_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		flt.enable && $past(flt.enable) && !$past(tick) |->
		$stable(filt_reg)) else $error("filter moved without a tick");
	a_filter_bypass: assert property (@(posedge clk_sys) disable iff (!resetn)
		// Reset lifts on a clock edge; that edge still holds the reset value
		resetn && !flt.enable |=> filt_reg == $past(flt.raw))
		else $error("bypassed filter did not follow input");
	a_div_two_tick: assert property (@(posedge clk_sys) disable iff (!resetn)
		flt.clk_sel == 3'h0 && tick |=> !tick)
		else $error("divide by two ticked twice in a row");
endmodule

// ---- hcd_flt_if.sv ----
/*
 Carrier between the decoder top and its hall noise filter.
 Assumes one system clock shared by both ends.
*/
`timescale 1ns/10ps
interface hcd_flt_if;
	logic [2:0] raw;
	logic       enable;
	logic [2:0] clk_sel;
	logic [4:0] checks;
	logic [2:0] filtered;
	modport filt (input raw, enable, clk_sel, checks, output filtered);
	modport user (output raw, enable, clk_sel, checks, input filtered);
endinterface

// ---- hcd_hall_model.sv ----
/*
 Model of the three hall sensors on the far side of the decoder.
 Assumes the bench picks the rotor step, angle layout and faults on clk_sys.
*/
`timescale 1ns/10ps
module hcd_hall_model
	import hcd_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       angle,
	input  wire logic [2:0] step,
	input  wire logic       bad,
	input  wire logic       glitch_a,
	output hcd_hall_type    hall
);
	logic [2:0] s60  [6] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
	logic [2:0] s120 [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};

	initial hall = 3'h4;

	// Sensors always drive; a fault shows the all-equal or split code
	always @(posedge clk_sys) begin
		if (bad)
			hall <= angle ? 3'h7 : 3'h5;
		else
			hall <= (angle ? s120[step] : s60[step]) ^ {glitch_a, 2'h0};
	end
endmodule

// ---- hcd_map.svh ----
/*
 Register offsets, field positions, reset values and encodings of the
 hall commutation decoder.
 Assumes byte addressing on a 32-bit register bus, one word per register.
*/
`ifndef HCD_MAP_SVH
`define HCD_MAP_SVH

`define HCD_OFS_CTL      8'h00
`define HCD_OFS_SOFT     8'h04
`define HCD_OFS_CHK      8'h08
`define HCD_OFS_FLT      8'h0c
`define HCD_OFS_EDGE     8'h10
`define HCD_OFS_IRQ_STAT 8'h14
`define HCD_OFS_IRQ_MASK 8'h18
`define HCD_OFS_TBL0     8'h20
`define HCD_TBL_COUNT    12
`define HCD_TBL_BACK     6

`define HCD_CTL_TSEL_LO  6
`define HCD_CTL_DLY      5
`define HCD_CTL_ANGLE    4
`define HCD_CTL_MODE     3
`define HCD_CTL_BRAKE    2
`define HCD_CTL_DIR      1
`define HCD_CTL_EN       0
`define HCD_CTL_RST      8'h10

`define HCD_FLT_EN       3
`define HCD_FLT_SEL_NONE 3'h7

`define HCD_EDGE_OFF     2'h0
`define HCD_EDGE_RISE    2'h1
`define HCD_EDGE_FALL    2'h2
`define HCD_EDGE_BOTH    2'h3

`define HCD_BRAKE_PAT    6'h15
`define HCD_STEP_BAD     3'h7

`define HCD_RESP_OKAY    2'h0
`define HCD_RESP_SLVERR  2'h2

`endif

// ---- hcd_pkg.sv ----
/*
 Types shared by the hall commutation decoder modules.
 Assumes hcd_map.svh is on the include path.
*/
package hcd_pkg;
	typedef logic [5:0] hcd_pat_type;
	typedef logic [2:0] hcd_hall_type;
	typedef enum logic [0:0] {
		HCD_DLY_IDLE,
		HCD_DLY_WAIT
	} hcd_dly_state_type;
endpackage

// ---- hcd_top.sv ----
/*
 Hall commutation decoder with AXI4-Lite registers, noise filter, timer
 driven delay path, commutation tables, brake and phase A edge interrupt.
 Assumes hall pins and timer match pulses are synchronous to clk_sys.
*/
// What this block does
// - Phase A edge select is 2 bits: off, rising, falling or both edges.
// - A 2-bit field picks which timer's compare-A match ends the delay.
// - Delay select 0 passes hall inputs straight, 1 routes them via delay.
// - Angle bit 0 picks 60 degree decoding, 1 picks 120, reset value 1.
// - Software mode takes soft hall bits 0..2, hardware the filtered pins.
// - Brake forces tops to 0 and bottoms to 1 whatever else is set.
// - Direction 0 uses the forward table and 1 the backward table.
// - Entries 0..5 hold forward patterns, 6..11 backward, per hall step.
// - Enable bit 1 turns decoding on, 0 off, and it resets to 0.
// - Without brake, disabled decoding or an invalid hall state drives all outputs 0.
// - Each of twelve entries holds six bits, A top in bit 5 to C bottom.
// - Unimplemented upper register bits read back as zero.
// - A 5-bit count sets how many checks the filter needs for a change.
// - Filter enable 0 bypasses the filter, 1 filters, reset value 0.
// - Filter clock select divides by 2 to 128 for codes 0..6; 7 stops sampling.
`timescale 1ns/10ps
`include "hcd_map.svh"
module hcd_top
	import hcd_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [2:0]  hall_pin_in,
	input  wire logic [2:0]  timer_match,
	output logic [2:0]       delay_timer_run,
	output logic             phase_a_top_out,
	output logic             phase_a_bottom_out,
	output logic             phase_b_top_out,
	output logic             phase_b_bottom_out,
	output logic             phase_c_top_out,
	output logic             phase_c_bottom_out,
	output logic             phase_a_interrupt
);
	logic [7:0]        ctl_reg;
	logic [2:0]        soft_hall_reg;
	logic [4:0]        chk_reg;
	logic [3:0]        flt_reg;
	logic [1:0]        edge_reg;
	logic              irq_stat_reg;
	logic              irq_mask_reg;
	hcd_pat_type       tbl_reg [`HCD_TBL_COUNT];
	logic              aw_got_reg;
	logic              w_got_reg;
	logic [7:0]        aw_addr_reg;
	logic [31:0]       w_data_reg;
	logic              w_lane0_reg;
	logic              wr_fire;
	logic [7:0]        wr_addr;
	logic [31:0]       wr_data;
	logic              wr_lane0;
	logic              rd_fire;
	logic [31:0]       rd_word;
	logic              rd_ok;
	logic              fha_prev_reg;
	logic              edge_hit;
	logic              irq_clear;
	hcd_hall_type      src_hall;
	hcd_hall_type      dly_hall_reg;
	hcd_hall_type      pend_hall_reg;
	hcd_dly_state_type dly_state_reg;
	logic              match_sel;
	hcd_hall_type      hall_sel;
	logic [2:0]        step;
	logic [3:0]        tbl_idx;
	hcd_pat_type       out_reg;
	hcd_pat_type       out_next;
	logic [2:0]        fh;
	hcd_flt_if         flt ();

	// Hall vector is {a, b, c}; step 7 marks a state with no table entry
	function automatic logic [2:0] hall_step(input logic [2:0] h,
		input logic angle);
		logic [2:0] s;
		s = `HCD_STEP_BAD;
		case (h)
			3'h4: s = 3'h0;
			3'h6: s = 3'h1;
			3'h3: s = 3'h3;
			3'h1: s = 3'h4;
			3'h7: s = angle ? `HCD_STEP_BAD : 3'h2;
			3'h2: s = angle ? 3'h2 : `HCD_STEP_BAD;
			3'h0: s = angle ? `HCD_STEP_BAD : 3'h5;
			3'h5: s = angle ? 3'h5 : `HCD_STEP_BAD;
			default: s = `HCD_STEP_BAD;
		endcase
		return s;
	endfunction

	function automatic logic is_tbl(input logic [7:0] a);
		return a >= `HCD_OFS_TBL0 &&
			a < `HCD_OFS_TBL0 + 8'(4 * `HCD_TBL_COUNT) && a[1:0] == 2'h0;
	endfunction

	function automatic logic [3:0] tbl_of(input logic [7:0] a);
		return 4'((a - `HCD_OFS_TBL0) >> 2);
	endfunction

	// Write channel: address and data are taken in either order
	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
	assign wr_addr  = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
	assign wr_data  = w_got_reg ? w_data_reg : s_axi_wdata;
	assign wr_lane0 = w_got_reg ? w_lane0_reg : s_axi_wstrb[0];
	assign wr_fire  = (aw_got_reg || (s_axi_awvalid && s_axi_awready)) &&
		(w_got_reg || (s_axi_wvalid && s_axi_wready));

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			aw_got_reg  <= 1'b0;
			w_got_reg   <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h0;
			w_lane0_reg <= 1'b0;
		end else if (wr_fire) begin
			aw_got_reg <= 1'b0;
			w_got_reg  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg  <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg   <= 1'b1;
				w_data_reg  <= s_axi_wdata;
				w_lane0_reg <= s_axi_wstrb[0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `HCD_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_addr == `HCD_OFS_CTL ||
				wr_addr == `HCD_OFS_SOFT || wr_addr == `HCD_OFS_CHK ||
				wr_addr == `HCD_OFS_FLT || wr_addr == `HCD_OFS_EDGE ||
				wr_addr == `HCD_OFS_IRQ_STAT ||
				wr_addr == `HCD_OFS_IRQ_MASK || is_tbl(wr_addr)) ?
				`HCD_RESP_OKAY : `HCD_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Registers are one byte wide, so only byte lane 0 writes them
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ctl_reg       <= `HCD_CTL_RST;
			soft_hall_reg <= 3'h0;
			chk_reg       <= 5'h00;
			flt_reg       <= 4'h0;
			edge_reg      <= `HCD_EDGE_OFF;
			irq_mask_reg  <= 1'b0;
			for (int i = 0; i < `HCD_TBL_COUNT; i++)
				tbl_reg[i] <= 6'h00;
		end else if (wr_fire && wr_lane0) begin
			case (wr_addr)
				`HCD_OFS_CTL:      ctl_reg <= wr_data[7:0];
				`HCD_OFS_SOFT:     soft_hall_reg <= wr_data[2:0];
				`HCD_OFS_CHK:      chk_reg <= wr_data[4:0];
				`HCD_OFS_FLT:      flt_reg <= wr_data[3:0];
				`HCD_OFS_EDGE:     edge_reg <= wr_data[1:0];
				`HCD_OFS_IRQ_MASK: irq_mask_reg <= wr_data[0];
				default: begin
					if (is_tbl(wr_addr))
						tbl_reg[tbl_of(wr_addr)] <= wr_data[5:0];
				end
			endcase
		end
	end

	// Read channel: answer one cycle after the address is taken
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	always_comb begin
		rd_word = 32'h0;
		rd_ok   = 1'b1;
		case (s_axi_araddr)
			`HCD_OFS_CTL:      rd_word[7:0] = ctl_reg;
			`HCD_OFS_SOFT:     rd_word[2:0] = soft_hall_reg;
			`HCD_OFS_CHK:      rd_word[4:0] = chk_reg;
			`HCD_OFS_FLT:      rd_word[3:0] = flt_reg;
			`HCD_OFS_EDGE:     rd_word[1:0] = edge_reg;
			`HCD_OFS_IRQ_STAT: rd_word[0] = irq_stat_reg;
			`HCD_OFS_IRQ_MASK: rd_word[0] = irq_mask_reg;
			default: begin
				if (is_tbl(s_axi_araddr))
					rd_word[5:0] = tbl_reg[tbl_of(s_axi_araddr)];
				else
					rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `HCD_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_ok ? `HCD_RESP_OKAY : `HCD_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	assign flt.raw     = hall_pin_in;
	assign flt.enable  = flt_reg[`HCD_FLT_EN];
	assign flt.clk_sel = flt_reg[2:0];
	assign flt.checks  = chk_reg;
	assign fh          = flt.filtered;

	hcd_filter u_filter (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.flt     (flt)
	);

	// Phase A edge interrupt watches the filtered pin, not the soft bits
	always_comb begin
		case (edge_reg)
			`HCD_EDGE_RISE: edge_hit = fh[2] && !fha_prev_reg;
			`HCD_EDGE_FALL: edge_hit = !fh[2] && fha_prev_reg;
			`HCD_EDGE_BOTH: edge_hit = fh[2] != fha_prev_reg;
			default:        edge_hit = 1'b0;
		endcase
	end

	assign irq_clear = wr_fire && wr_lane0 &&
		wr_addr == `HCD_OFS_IRQ_STAT && wr_data[0];

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			fha_prev_reg <= 1'b0;
			irq_stat_reg <= 1'b0;
		end else begin
			fha_prev_reg <= fh[2];
			// A new edge outranks a clear in the same cycle
			if (edge_hit)
				irq_stat_reg <= 1'b1;
			else if (irq_clear)
				irq_stat_reg <= 1'b0;
		end
	end

	assign phase_a_interrupt = irq_stat_reg && irq_mask_reg;

	// Soft bit 0 is hall A, so the soft word is reversed into {a, b, c}
	assign src_hall = ctl_reg[`HCD_CTL_MODE] ? fh :
		{soft_hall_reg[0], soft_hall_reg[1], soft_hall_reg[2]};

	// Select code 3 names no timer, so a delayed state would never release
	always_comb begin
		case (ctl_reg[7:`HCD_CTL_TSEL_LO])
			2'h0:    match_sel = timer_match[0];
			2'h1:    match_sel = timer_match[1];
			2'h2:    match_sel = timer_match[2];
			default: match_sel = 1'b0;
		endcase
	end

	// Only one change is held; a delay longer than a step loses steps
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			dly_state_reg <= HCD_DLY_IDLE;
			dly_hall_reg  <= 3'h0;
			pend_hall_reg <= 3'h0;
		end else if (!ctl_reg[`HCD_CTL_DLY]) begin
			dly_state_reg <= HCD_DLY_IDLE;
			dly_hall_reg  <= src_hall;
			pend_hall_reg <= 3'h0;
		end else begin
			case (dly_state_reg)
				HCD_DLY_IDLE: begin
					if (src_hall != dly_hall_reg) begin
						pend_hall_reg <= src_hall;
						dly_state_reg <= HCD_DLY_WAIT;
					end
				end
				HCD_DLY_WAIT: begin
					if (match_sel) begin
						dly_hall_reg  <= pend_hall_reg;
						dly_state_reg <= HCD_DLY_IDLE;
					end
				end
				default: dly_state_reg <= HCD_DLY_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn)
			delay_timer_run <= 3'h0;
		else if (dly_state_reg == HCD_DLY_WAIT && !match_sel &&
			ctl_reg[`HCD_CTL_DLY])
			delay_timer_run <= 3'(4'h1 << ctl_reg[7:`HCD_CTL_TSEL_LO]);
		else
			delay_timer_run <= 3'h0;
	end

	assign hall_sel = ctl_reg[`HCD_CTL_DLY] ? dly_hall_reg : src_hall;
	assign step     = hall_step(hall_sel, ctl_reg[`HCD_CTL_ANGLE]);
	assign tbl_idx  = ctl_reg[`HCD_CTL_DIR] ?
		4'(step) + 4'(`HCD_TBL_BACK) : 4'(step);

	always_comb begin
		if (ctl_reg[`HCD_CTL_BRAKE])
			out_next = `HCD_BRAKE_PAT;
		else if (!ctl_reg[`HCD_CTL_EN] || step == `HCD_STEP_BAD)
			out_next = 6'h00;
		else
			out_next = tbl_reg[tbl_idx];
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn)
			out_reg <= 6'h00;
		else
			out_reg <= out_next;
	end

	assign phase_a_top_out    = out_reg[5];
	assign phase_a_bottom_out = out_reg[4];
	assign phase_b_top_out    = out_reg[3];
	assign phase_b_bottom_out = out_reg[2];
	assign phase_c_top_out    = out_reg[1];
	assign phase_c_bottom_out = out_reg[0];

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_decode_fwd;
		ctl_reg[`HCD_CTL_EN] && !ctl_reg[`HCD_CTL_BRAKE] &&
		!ctl_reg[`HCD_CTL_DIR] && step != `HCD_STEP_BAD;
	endsequence
	sequence s_decode_back;
		ctl_reg[`HCD_CTL_EN] && !ctl_reg[`HCD_CTL_BRAKE] &&
		ctl_reg[`HCD_CTL_DIR] && step != `HCD_STEP_BAD;
	endsequence

	a_brake_pattern: assert property (
		ctl_reg[`HCD_CTL_BRAKE] |=> out_reg == 6'h15)
		else $error("brake pattern wrong");
	a_disabled_zero: assert property (
		!ctl_reg[`HCD_CTL_BRAKE] && !ctl_reg[`HCD_CTL_EN] |=> out_reg == 0)
		else $error("disabled decoder drove outputs");
	a_invalid_zero: assert property (
		!ctl_reg[`HCD_CTL_BRAKE] && hall_sel == 3'h7 &&
		ctl_reg[`HCD_CTL_ANGLE] |=> out_reg == 0)
		else $error("invalid hall state drove outputs");
	a_forward_table: assert property (
		s_decode_fwd |=> out_reg == $past(tbl_reg[step]))
		else $error("forward table not used");
	a_backward_table: assert property (
		s_decode_back |=> out_reg == $past(tbl_reg[4'(step) + 4'h6]))
		else $error("backward table not used");
	a_rise_sets_irq: assert property (
		edge_reg == 2'h1 && fh[2] && !fha_prev_reg |=> irq_stat_reg)
		else $error("rising edge missed");
	a_off_no_irq: assert property (
		edge_reg == 2'h0 && !irq_stat_reg |=> !irq_stat_reg)
		else $error("disabled edge set status");
	a_read_upper_zero: assert property (
		rd_fire && s_axi_araddr == 8'h04 |=> s_axi_rdata[31:3] == 0)
		else $error("soft hall upper bits nonzero");
	a_soft_source: assert property (
		!ctl_reg[`HCD_CTL_MODE] && !ctl_reg[`HCD_CTL_DLY] |->
		hall_sel == {soft_hall_reg[0], soft_hall_reg[1],
		soft_hall_reg[2]}) else $error("soft source not used");
	a_delay_release: assert property (
		dly_state_reg == HCD_DLY_WAIT && ctl_reg[`HCD_CTL_DLY] &&
		match_sel |=> dly_hall_reg == $past(pend_hall_reg))
		else $error("delayed state not released on match");
endmodule

// ---- hcd_top_bench.sv ----
/*
 Self-checking bench for the hall commutation decoder.
 Assumes hcd_map.svh on the include path and the hall sensor model.
*/
`timescale 1ns/10ps
`include "hcd_map.svh"
module hcd_top_bench;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [2:0]  step = 3'h0;
	logic [2:0]  tmatch = 3'h0;
	logic        angle = 1'b0;
	logic        bad = 1'b0;
	logic        glitch_a = 1'b0;
	logic [2:0]  cur = 3'h0;
	wire         awready, wready, bvalid, arready, rvalid, irq;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [2:0]  hall, run;
	wire  [5:0]  outs;
	int          bad_count = 0;
	int          num_checks = 0;
	logic [2:0]  s60 [6] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};

	always #12.5 clk_sys = ~clk_sys;

	hcd_hall_model hcd_hall_model_i (.clk_sys(clk_sys), .angle(angle),
		.step(step), .bad(bad), .glitch_a(glitch_a), .hall(hall));

	hcd_top hcd_top_i (.clk_sys(clk_sys), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .hall_pin_in(hall), .timer_match(tmatch),
		.delay_timer_run(run), .phase_a_top_out(outs[5]),
		.phase_a_bottom_out(outs[4]), .phase_b_top_out(outs[3]),
		.phase_b_bottom_out(outs[2]), .phase_c_top_out(outs[1]),
		.phase_c_bottom_out(outs[0]), .phase_a_interrupt(irq));

	function automatic logic [5:0] pat(int n);
		return 6'(n * 7 + 9);
	endfunction

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tmo(string nm);
		bad_count++;
		$display("BAD %s expected answer seen timeout", nm);
		complete_run();
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er = 2'h0);
		logic ta, tw, bv;
		logic [1:0] r;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk_sys);
			ta = awvalid && awready;
			tw = wvalid && wready;
			bv = bvalid;
			r = bresp;
			@(posedge clk_sys);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (bv) begin
				bready <= 1'b0;
				chk("bresp", 32'(er), 32'(r));
				return;
			end
		end
		tmo("write");
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er = 2'h0);
		logic ta, rv;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk_sys);
			ta = arvalid && arready;
			rv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (ta)
				arvalid <= 1'b0;
			if (rv) begin
				rready <= 1'b0;
				chk("rdata", e, d);
				chk("rresp", 32'(er), 32'(r));
				return;
			end
		end
		tmo("read");
	endtask

	task automatic tk(int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic mv(logic [2:0] s);
		@(posedge clk_sys);
		step <= s;
	endtask

	task automatic co(logic [5:0] e);
		@(negedge clk_sys);
		chk("outs", 32'(e), 32'(outs));
	endtask

	task automatic ci(string nm, logic e);
		@(negedge clk_sys);
		chk(nm, 32'(e), 32'(irq));
	endtask

	// Any departure during the window is kept so one compare reports it
	task automatic hold(logic [5:0] e, int n);
		logic [5:0] g;
		g = e;
		repeat (n) begin
			@(negedge clk_sys);
			if (outs !== e)
				g = outs;
		end
		chk("outs held", 32'(e), 32'(g));
	endtask

	task automatic wt(logic [5:0] e, int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys);
			if (outs === e) begin
				chk("outs", 32'(e), 32'(outs));
				return;
			end
		end
		tmo("outs");
	endtask

	task automatic reg_access;
		rd(`HCD_OFS_CTL, 32'h10);
		rd(`HCD_OFS_FLT, 32'h0);
		rd(8'h60, 32'h0, `HCD_RESP_SLVERR);
		wr(8'h60, 8'h01, `HCD_RESP_SLVERR);
		for (int n = 0; n < 12; n++) begin
			wr(8'(`HCD_OFS_TBL0 + 4 * n), {2'h3, pat(n)});
			rd(8'(`HCD_OFS_TBL0 + 4 * n), 32'(pat(n)));
		end
		wr(`HCD_OFS_SOFT, 8'hff);
		rd(`HCD_OFS_SOFT, 32'h7);
		wr(`HCD_OFS_CHK, 8'hff);
		rd(`HCD_OFS_CHK, 32'h1f);
	endtask

	task automatic soft_decode;
		for (int d = 0; d < 2; d++) begin
			wr(`HCD_OFS_CTL, 8'(1 + 2 * d));
			for (int s = 0; s < 6; s++) begin
				cur = s60[s];
				wr(`HCD_OFS_SOFT, {5'h0, cur[0], cur[1], cur[2]});
				co(pat(s + 6 * d));
			end
		end
		wr(`HCD_OFS_SOFT, 8'h05);
		co(6'h0);
		wr(`HCD_OFS_SOFT, 8'h02);
		co(6'h0);
		wr(`HCD_OFS_CTL, 8'h07);
		co(`HCD_BRAKE_PAT);
		wr(`HCD_OFS_CTL, 8'h04);
		co(`HCD_BRAKE_PAT);
		wr(`HCD_OFS_SOFT, 8'h04);
		wr(`HCD_OFS_CTL, 8'h00);
		co(6'h0);
	endtask

	task automatic hw_decode;
		@(posedge clk_sys);
		angle <= 1'b1;
		wr(`HCD_OFS_CTL, 8'h19);
		for (int s = 0; s < 6; s++) begin
			mv(3'(s));
			tk(3);
			co(pat(s));
		end
		@(posedge clk_sys);
		bad <= 1'b1;
		tk(3);
		co(6'h0);
		@(posedge clk_sys);
		bad <= 1'b0;
		mv(3'h0);
		tk(3);
	endtask

	task automatic irq_edges;
		for (int e = 0; e < 4; e++) begin
			wr(`HCD_OFS_EDGE, 8'(e));
			wr(`HCD_OFS_IRQ_MASK, 8'h01);
			wr(`HCD_OFS_IRQ_STAT, 8'h01);
			mv(3'h3);
			tk(4);
			rd(`HCD_OFS_IRQ_STAT, 32'(e >> 1));
			ci("irq", 1'(e >> 1));
			wr(`HCD_OFS_IRQ_STAT, 8'h01);
			mv(3'h0);
			tk(4);
			rd(`HCD_OFS_IRQ_STAT, 32'(e & 1));
			ci("irq", 1'(e & 1));
			wr(`HCD_OFS_IRQ_STAT, 8'h01);
		end
		wr(`HCD_OFS_IRQ_MASK, 8'h00);
		mv(3'h3);
		tk(4);
		ci("irq masked", 1'b0);
		wr(`HCD_OFS_IRQ_MASK, 8'h01);
		ci("irq unmasked", 1'b1);
		wr(`HCD_OFS_IRQ_STAT, 8'h01);
		ci("irq cleared", 1'b0);
		cur = 3'h3;
	endtask

	task automatic filter_timing;
		logic [2:0] nxt;
		wr(`HCD_OFS_CHK, 8'h03);
		wr(`HCD_OFS_FLT, 8'h08);
		@(posedge clk_sys);
		glitch_a <= 1'b1;
		@(posedge clk_sys);
		glitch_a <= 1'b0;
		hold(pat(cur), 16);
		wr(`HCD_OFS_CHK, 8'h02);
		for (int c = 0; c < 7; c++) begin
			wr(`HCD_OFS_FLT, 8'(8 + c));
			nxt = (cur == 3'h3) ? 3'h0 : 3'h3;
			mv(nxt);
			hold(pat(cur), 2 << c);
			wt(pat(nxt), (2 << c) + 4);
			cur = nxt;
		end
		wr(`HCD_OFS_FLT, 8'h0f);
		nxt = (cur == 3'h3) ? 3'h0 : 3'h3;
		mv(nxt);
		hold(pat(cur), 300);
		wr(`HCD_OFS_FLT, 8'h00);
		wt(pat(nxt), 4);
		cur = nxt;
	endtask

	task automatic delay_path;
		logic [2:0] nxt;
		for (int t = 0; t < 3; t++) begin
			wr(`HCD_OFS_CTL, 8'(8'h39 | (t << 6)));
			nxt = (cur == 3'h3) ? 3'h0 : 3'h3;
			mv(nxt);
			hold(pat(cur), 6);
			chk("timer run", 32'(1 << t), 32'(run));
			@(posedge clk_sys);
			tmatch <= 3'(1 << ((t + 1) % 3));
			@(posedge clk_sys);
			tmatch <= 3'h0;
			hold(pat(cur), 4);
			@(posedge clk_sys);
			tmatch <= 3'(1 << t);
			@(posedge clk_sys);
			tmatch <= 3'h0;
			wt(pat(nxt), 4);
			cur = nxt;
		end
	endtask

	initial begin
		tk(20);
		resetn <= 1'b1;
		tk(2);
		reg_access();
		soft_decode();
		hw_decode();
		irq_edges();
		filter_timing();
		delay_path();
		complete_run();
	end
endmodule
